// ===== pkg/hisp_pkg.sv
// Shared constants and types for the host interface selection port.
// Assumes both ends run on one 50 MHz clock with active-low async reset.
package hisp_pkg;
    // Interface select pattern {bit0, bit1, bit2}
    localparam logic [2:0] SEL_ENABLE_STROBE = 3'h1;
    localparam logic [2:0] SEL_SEPARATE_STROBE = 3'h3;
    localparam logic [2:0] SEL_SPI4 = 3'h0;
    localparam logic [2:0] SEL_SPI3 = 3'h4;
    localparam logic [2:0] SEL_I2C = 3'h2;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int STROBE_CYCLES = 4;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RAM_DATA_RESET = 8'h00;
    localparam int RAM_WORDS = 16;
    typedef enum logic [2:0] {
        MODE_ENABLE_STROBE,
        MODE_SEPARATE_STROBE,
        MODE_SPI4,
        MODE_SPI3,
        MODE_I2C
    } hisp_mode_e;
endpackage : hisp_pkg

// ===== pkg/hisp_bus_if.sv
// Pad-level bus between the host end and the device end.
// Assumes the testbench resolves the data pads from both enables.
`timescale 1ns/1ps
interface hisp_bus_if;
    logic [2:0] ifaceSel;
    logic cmdDataSelect;
    logic chipSelectPadN;
    logic readStrobePad;
    logic writeStrobePad;
    logic [7:0] hostDataOut;
    logic [7:0] hostDataOe;
    logic [7:0] devDataOut;
    logic [7:0] devDataOe;
    logic [7:0] padData;
    modport device (
        input ifaceSel, cmdDataSelect, chipSelectPadN, readStrobePad, writeStrobePad, padData,
        output devDataOut, devDataOe
    );
    modport host (
        input padData,
        output ifaceSel, cmdDataSelect, chipSelectPadN, readStrobePad, writeStrobePad,
        output hostDataOut, hostDataOe
    );
endinterface : hisp_bus_if

// ===== src/hisp_fifo.sv
// Parameterised valid/ready FIFO.
// Assumes a single clock domain.
`timescale 1ns/1ps
module hisp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
    logic [AW:0] count_ff, nxt_count;
    logic doWr, doRd;
    always_comb begin
        doWr = inValid && inReady;
        doRd = outValid && outReady;
        nxt_wrPtr = doWr ? wrPtr_ff + 1'b1 : wrPtr_ff;
        nxt_rdPtr = doRd ? rdPtr_ff + 1'b1 : rdPtr_ff;
        nxt_count = count_ff + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else begin
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= nxt_count;
        end
    end
    // Storage has no reset so it maps to RAM
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_ff] <= inData;
        end
    end
    assign inReady = count_ff != (AW+1)'(DEPTH);
    assign outValid = count_ff != '0;
    assign outData = mem[rdPtr_ff];
endmodule : hisp_fifo

// ===== src/hisp_host.sv
// Host end: drives parallel bus cycles from a request stream.
// Assumes the device end shares clk; ifaceSel is a static strap.
`timescale 1ns/1ps
module hisp_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pad bus
    hisp_bus_if.host bus,
    // User side
    input wire logic [2:0] modeSel,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire logic reqCmdData,
    input wire logic [7:0] reqData,
    output logic rspValid,
    output logic [7:0] rspData
);
    typedef enum logic [1:0] {IDLE, ACTIVE, HOLD} hisp_hst_e;
    hisp_hst_e st_ff, nxt_st;
    logic [2:0] cnt_ff, nxt_cnt;
    logic rd_ff, nxt_rd, cd_ff, nxt_cd, csN_ff, nxt_csN, rs_ff, nxt_rs, ws_ff, nxt_ws;
    logic [7:0] d_ff, nxt_d, oe_ff, nxt_oe, rsp_ff, nxt_rsp;
    logic rv_ff, nxt_rv, rdy_ff, nxt_rdy;
    logic [2:0] sel_ff;
    logic [7:0] padS1_ff, padS2_ff;
    logic par, enStb;
    always_comb begin
        par = modeSel == hisp_pkg::SEL_ENABLE_STROBE || modeSel == hisp_pkg::SEL_SEPARATE_STROBE;
        enStb = modeSel == hisp_pkg::SEL_ENABLE_STROBE;
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_rd = rd_ff;
        nxt_cd = cd_ff;
        nxt_csN = csN_ff;
        nxt_rs = rs_ff;
        nxt_ws = ws_ff;
        nxt_d = d_ff;
        nxt_oe = oe_ff;
        nxt_rsp = rsp_ff;
        nxt_rv = 1'b0;
        nxt_rdy = 1'b0;
        case (st_ff)
            IDLE: begin
                nxt_rs = !enStb;
                nxt_ws = enStb ? 1'b1 : 1'b1;
                nxt_csN = 1'b1;
                nxt_oe = 8'h00;
                if (reqValid && par && !rdy_ff) begin
                    nxt_rd = reqRead;
                    nxt_cd = reqCmdData;
                    nxt_d = reqData;
                    nxt_csN = 1'b0;
                    nxt_oe = reqRead ? 8'h00 : 8'hFF;
                    nxt_ws = enStb ? reqRead : reqRead;
                    nxt_cnt = '0;
                    nxt_st = ACTIVE;
                end
            end
            ACTIVE: begin
                nxt_cnt = cnt_ff + 3'h1;
                if (cnt_ff < 3'(hisp_pkg::STROBE_CYCLES - 1)) begin
                    nxt_rs = enStb ? 1'b1 : rd_ff ? 1'b0 : 1'b1;
                    nxt_ws = enStb ? rd_ff : (rd_ff ? 1'b1 : 1'b0);
                end else begin
                    nxt_rs = !enStb;
                    nxt_ws = enStb ? rd_ff : 1'b1;
                end
                // Read data reaches us through both sync stages late
                if (cnt_ff == 3'(hisp_pkg::STROBE_CYCLES + 2)) begin
                    nxt_rsp = padS2_ff;
                    nxt_st = HOLD;
                end
            end
            HOLD: begin
                nxt_csN = 1'b1;
                nxt_oe = 8'h00;
                nxt_rv = rd_ff;
                nxt_rdy = 1'b1;
                nxt_st = IDLE;
            end
            default: nxt_st = IDLE;
        endcase
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= IDLE;
            cnt_ff <= '0;
            rd_ff <= 1'b0;
            cd_ff <= 1'b0;
            csN_ff <= 1'b1;
            rs_ff <= 1'b1;
            ws_ff <= 1'b1;
            d_ff <= 8'h00;
            oe_ff <= 8'h00;
            rsp_ff <= 8'h00;
            rv_ff <= 1'b0;
            rdy_ff <= 1'b0;
            sel_ff <= hisp_pkg::SEL_SPI4;
            padS1_ff <= 8'h00;
            padS2_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            rd_ff <= nxt_rd;
            cd_ff <= nxt_cd;
            csN_ff <= nxt_csN;
            rs_ff <= nxt_rs;
            ws_ff <= nxt_ws;
            d_ff <= nxt_d;
            oe_ff <= nxt_oe;
            rsp_ff <= nxt_rsp;
            rv_ff <= nxt_rv;
            rdy_ff <= nxt_rdy;
            sel_ff <= modeSel;
            padS1_ff <= bus.padData;
            padS2_ff <= padS1_ff;
        end
    end
    assign bus.ifaceSel = sel_ff;
    assign bus.cmdDataSelect = cd_ff;
    assign bus.chipSelectPadN = csN_ff;
    assign bus.readStrobePad = rs_ff;
    assign bus.writeStrobePad = ws_ff;
    assign bus.hostDataOut = d_ff;
    assign bus.hostDataOe = oe_ff;
    assign reqReady = rdy_ff;
    assign rspValid = rv_ff;
    assign rspData = rsp_ff;
endmodule : hisp_host

// ===== src/hisp_device.sv
// Device end: decodes the interface straps and parallel bus cycles.
// Assumes pads come from outside the clock domain; writes leave via a FIFO.
// Notes on behaviour
// - Three mode pins choose one of five interfaces
// - Serial modes float the upper six data pads
// - Parallel modes: eight data pads, select, strobes
// - Enable-strobe mode: direction high means read
// - Enable-strobe mode: direction low means write
// - Enable strobe acts only with chip select low
// - Enable-strobe RAM reads need one dummy read
// - Separate mode: read strobe low, select low reads
// - Separate mode: write strobe low, select low writes
// - Separate mode RAM reads also one read late
// - Select high is data, low command or status
`timescale 1ns/1ps
module hisp_device #(
    parameter int DEPTH = hisp_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Pad bus
    hisp_bus_if.device bus,
    // Write stream to the core
    output logic wrValid,
    input wire logic wrReady,
    output logic wrIsData,
    output logic [7:0] wrByte,
    // Core read sources
    input wire logic [7:0] statusByte,
    input wire logic [7:0] ramByte,
    output logic ramReadPulse,
    // Decoded mode and serial pads
    output logic [2:0] activeMode,
    output logic serialClk,
    output logic serialData
);
    logic [2:0] sel1_ff, sel2_ff;
    logic [3:0] ctl1_ff, ctl2_ff, ctlPrev_ff;
    logic [7:0] pad1_ff, pad2_ff;
    logic [7:0] rdLatch_ff, nxt_rdLatch, pipe_ff, nxt_pipe;
    logic [7:0] oe_ff, nxt_oe;
    logic [2:0] mode_ff, nxt_mode;
    logic sck_ff, sdi_ff, rp_ff, nxt_rp;
    logic csN, cd, rs, ws, pRs, pWs, isPar, enStb, actNow, actPrev, rdNow, wrEdge, rdEdge;
    logic fInValid, fInReady, fOutValid;
    logic [8:0] fOutData;
    always_comb begin
        isPar = sel2_ff == hisp_pkg::SEL_ENABLE_STROBE || sel2_ff == hisp_pkg::SEL_SEPARATE_STROBE;
        enStb = sel2_ff == hisp_pkg::SEL_ENABLE_STROBE;
        {csN, cd, rs, ws} = ctl2_ff;
        pRs = ctlPrev_ff[1];
        pWs = ctlPrev_ff[0];
        // Strobe active: E high or RD/WR low, gated by chip select
        actNow = !csN && (enStb ? rs : (!rs || !ws));
        actPrev = !ctlPrev_ff[3] && (enStb ? pRs : (!pRs || !pWs));
        rdNow = enStb ? ws : !rs;
        // Writes latch on the trailing edge of the strobe, when data is settled; reads latch on the leading edge
        wrEdge = isPar && actPrev && !actNow && !(enStb ? pWs : pWs);
        rdEdge = isPar && !actPrev && actNow && rdNow;
        fInValid = wrEdge;
        nxt_rdLatch = rdLatch_ff;
        nxt_pipe = pipe_ff;
        nxt_rp = 1'b0;
        if (rdEdge) begin
            // RAM data lags one read so the first is a dummy
            nxt_rdLatch = cd ? pipe_ff : statusByte;
            if (cd) begin
                nxt_pipe = ramByte;
                nxt_rp = 1'b1;
            end
        end
        nxt_oe = (isPar && actNow && rdNow) ? 8'hFF : 8'h00;
        case (sel2_ff)
            hisp_pkg::SEL_ENABLE_STROBE: nxt_mode = 3'(hisp_pkg::MODE_ENABLE_STROBE);
            hisp_pkg::SEL_SEPARATE_STROBE: nxt_mode = 3'(hisp_pkg::MODE_SEPARATE_STROBE);
            hisp_pkg::SEL_SPI4: nxt_mode = 3'(hisp_pkg::MODE_SPI4);
            hisp_pkg::SEL_SPI3: nxt_mode = 3'(hisp_pkg::MODE_SPI3);
            hisp_pkg::SEL_I2C: nxt_mode = 3'(hisp_pkg::MODE_I2C);
            default: nxt_mode = 3'(hisp_pkg::MODE_SPI4);
        endcase
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sel1_ff <= hisp_pkg::SEL_SPI4;
            sel2_ff <= hisp_pkg::SEL_SPI4;
            ctl1_ff <= 4'hF;
            ctl2_ff <= 4'hF;
            ctlPrev_ff <= 4'hF;
            pad1_ff <= 8'h00;
            pad2_ff <= 8'h00;
            rdLatch_ff <= hisp_pkg::STATUS_RESET;
            pipe_ff <= hisp_pkg::RAM_DATA_RESET;
            oe_ff <= 8'h00;
            mode_ff <= 3'(hisp_pkg::MODE_SPI4);
            sck_ff <= 1'b0;
            sdi_ff <= 1'b0;
            rp_ff <= 1'b0;
        end else begin
            sel1_ff <= bus.ifaceSel;
            sel2_ff <= sel1_ff;
            ctl1_ff <= {bus.chipSelectPadN, bus.cmdDataSelect, bus.readStrobePad,
                bus.writeStrobePad};
            ctl2_ff <= ctl1_ff;
            ctlPrev_ff <= ctl2_ff;
            pad1_ff <= bus.padData;
            pad2_ff <= pad1_ff;
            rdLatch_ff <= nxt_rdLatch;
            pipe_ff <= nxt_pipe;
            oe_ff <= nxt_oe;
            mode_ff <= nxt_mode;
            // Strobes are ignored in serial modes; only pads 0 and 1 pass
            sck_ff <= isPar ? 1'b0 : pad2_ff[0];
            sdi_ff <= isPar ? 1'b0 : pad2_ff[1];
            rp_ff <= nxt_rp;
        end
    end
    // Write bytes queue here; a full queue drops further strobes
    hisp_fifo #(
        .WIDTH(9),
        .DEPTH(DEPTH)
    ) uFifo (
        .clk(clk),
        .rstn(rstn),
        .inValid(fInValid),
        .inReady(fInReady),
        .inData({cd, pad2_ff}),
        .outValid(fOutValid),
        .outReady(wrReady),
        .outData(fOutData)
    );
    assign wrValid = fOutValid;
    assign wrIsData = fOutData[8];
    assign wrByte = fOutData[7:0];
    assign bus.devDataOut = rdLatch_ff;
    assign bus.devDataOe = oe_ff;
    assign ramReadPulse = rp_ff;
    assign activeMode = mode_ff;
    assign serialClk = sck_ff;
    assign serialData = sdi_ff;
endmodule : hisp_device

// ===== tb/hisp_props.sv
// Checker of the pad bus between the two ends.
// Assumes one clock; placed beside the bus interface.
`timescale 1ns/1ps
module hisp_props (
    // Clock, reset
    input wire logic clk,
    input wire logic rstn,
    // Pads
    input wire logic [2:0] ifaceSel,
    input wire logic chipSelectPadN,
    input wire logic readStrobePad,
    input wire logic writeStrobePad,
    input wire logic [7:0] hostDataOe,
    input wire logic [7:0] devDataOe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic enMode, sepMode;
    assign enMode = ifaceSel == hisp_pkg::SEL_ENABLE_STROBE;
    assign sepMode = ifaceSel == hisp_pkg::SEL_SEPARATE_STROBE;
    sequence s_enRead;
        (enMode && readStrobePad && writeStrobePad && !chipSelectPadN) [*3];
    endsequence
    sequence s_sepRead;
        (sepMode && !readStrobePad && !chipSelectPadN) [*3];
    endsequence
    sequence s_write;
        ((enMode || sepMode) && !writeStrobePad && !chipSelectPadN) [*3];
    endsequence
    property p_enRead;
        s_enRead |-> ##[0:3] devDataOe == 8'hFF;
    endproperty
    a_enRead: assert property (p_enRead) else $error("read not driven");
    property p_sepRead;
        s_sepRead |-> ##[0:3] devDataOe == 8'hFF;
    endproperty
    a_sepRead: assert property (p_sepRead) else $error("read not driven");
    property p_write;
        s_write |-> devDataOe == 8'h00;
    endproperty
    a_write: assert property (p_write) else $error("driven on write");
    // Serial modes drive no data pad and keep chip select high
    property p_serQuiet;
        !(enMode || sepMode) |-> devDataOe == 8'h00 && chipSelectPadN;
    endproperty
    a_serQuiet: assert property (p_serQuiet) else $error("serial pads driven");
    property p_noClash;
        (hostDataOe & devDataOe) == 8'h00;
    endproperty
    a_noClash: assert property (p_noClash) else $error("both ends drive");
    property p_wholeByte;
        devDataOe inside {8'h00, 8'hFF} && hostDataOe inside {8'h00, 8'hFF};
    endproperty
    a_wholeByte: assert property (p_wholeByte) else $error("partial byte");
    // Sync delay allowed before release
    property p_csIdle;
        chipSelectPadN [*4] |-> devDataOe == 8'h00;
    endproperty
    a_csIdle: assert property (p_csIdle) else $error("driven unselected");
    property p_sepStrobe;
        sepMode && $fell(writeStrobePad) |->
            (!writeStrobePad && !chipSelectPadN) [*4] ##1 (writeStrobePad && !chipSelectPadN);
    endproperty
    a_sepStrobe: assert property (p_sepStrobe) else $error("bad write strobe");
endmodule : hisp_props

// ===== tb/testbench.sv
// Bench: host end drives the device end over the pad bus.
// Assumes 50 MHz clk; undriven pads show a changing pattern.
`timescale 1ns/1ps
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errorCnt++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
    logic clk, rstn, reqValid, reqReady, reqRead, reqCmdData, rspValid;
    logic wrValid, wrReady, wrIsData, ramReadPulse, serialClk, serialData;
    logic fillHold, padHold, dummyDue;
    logic [2:0] modeSel, activeMode;
    logic [7:0] reqData, rspData, wrByte, statusByte, ramByte, floatPad, ramBase;
    logic [9:0] wrQ[$], rdQ[$];
    logic [9:0] wExp, rExp;
    logic [2:0] sels[5] = '{hisp_pkg::SEL_ENABLE_STROBE, hisp_pkg::SEL_SEPARATE_STROBE,
        hisp_pkg::SEL_SPI4, hisp_pkg::SEL_SPI3, hisp_pkg::SEL_I2C};
    int errorCnt = 0;
    int numChecks = 0;
    int seed = 32'h06b00d6f;
    hisp_bus_if bus();
    assign bus.padData = (bus.hostDataOut & bus.hostDataOe) | (bus.devDataOut & bus.devDataOe)
        | (floatPad & ~bus.hostDataOe & ~bus.devDataOe);
    hisp_host i_hisp_host (.clk(clk), .rstn(rstn), .bus(bus.host), .modeSel(modeSel),
        .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead),
        .reqCmdData(reqCmdData), .reqData(reqData), .rspValid(rspValid), .rspData(rspData));
    hisp_device i_hisp_device (.clk(clk), .rstn(rstn), .bus(bus.device),
        .wrValid(wrValid), .wrReady(wrReady), .wrIsData(wrIsData), .wrByte(wrByte),
        .statusByte(statusByte), .ramByte(ramByte), .ramReadPulse(ramReadPulse),
        .activeMode(activeMode), .serialClk(serialClk), .serialData(serialData));
    hisp_props i_hisp_props (.clk(clk), .rstn(rstn), .ifaceSel(bus.ifaceSel),
        .chipSelectPadN(bus.chipSelectPadN), .readStrobePad(bus.readStrobePad),
        .writeStrobePad(bus.writeStrobePad), .hostDataOe(bus.hostDataOe),
        .devDataOe(bus.devDataOe));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Display RAM stand-in advances on each fetch
    always @(posedge clk) begin
        wrReady <= !fillHold && 1'($random(seed));
        if (!padHold)
            floatPad <= 8'($random(seed));
        if (ramReadPulse === 1'b1)
            ramByte <= ramByte + 8'h01;
    end
    always @(posedge clk) begin
        if (wrValid === 1'b1 && wrReady) begin
            wExp = (wrQ.size() > 0) ? wrQ.pop_front() : 10'h000;
            `CHK({1'b1, wrIsData, wrByte}, wExp)
        end
        if (rspValid === 1'b1) begin
            rExp = (rdQ.size() > 0) ? rdQ.pop_front() : 10'h000;
            if (!rExp[8])
                `CHK({1'b1, rspData}, {rExp[9], rExp[7:0]})
        end
    end
    task automatic endSim();
        if (errorCnt == 0 && numChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : endSim
    task automatic doReset(input logic [2:0] sel);
        rstn <= 1'b0;
        modeSel <= sel;
        dummyDue = 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask : doReset
    // First data read after reset is the pipeline dummy
    task automatic xfer(input logic rd, input logic cd, input logic keep);
        logic [7:0] d;
        d = 8'($random(seed));
        @(posedge clk);
        {reqValid, reqRead, reqCmdData} <= {1'b1, rd, cd};
        reqData <= d;
        statusByte <= d;
        if (!rd && keep)
            wrQ.push_back({1'b1, cd, d});
        else if (rd && !cd)
            rdQ.push_back({2'b10, d});
        else if (rd) begin
            rdQ.push_back({1'b1, dummyDue, ramBase});
            ramBase = dummyDue ? ramByte : ramBase + 8'h01;
            dummyDue = 1'b0;
        end
        for (int n = 0; n < 40 && reqReady !== 1'b1; n++)
            @(posedge clk);
        reqValid <= 1'b0;
        if (reqReady !== 1'b1) begin
            errorCnt++;
            endSim();
        end
    endtask : xfer
    task automatic drain();
        for (int n = 0; n < 500 && wrQ.size() > 0; n++)
            @(posedge clk);
        if (wrQ.size() > 0) begin
            errorCnt++;
            endSim();
        end
    endtask : drain
    initial begin
        {rstn, reqValid, reqRead, reqCmdData, wrReady, fillHold, padHold} = '0;
        {reqData, statusByte, floatPad, ramBase} = '0;
        ramByte = 8'h40;
        modeSel = hisp_pkg::SEL_ENABLE_STROBE;
        for (int m = 0; m < 5; m++) begin
            doReset(sels[m]);
            repeat (4) @(posedge clk);
            `CHK(activeMode, 3'(m))
            if (m < 2) begin
                xfer(1'b0, 1'b1, 1'b1);
                xfer(1'b0, 1'b0, 1'b1);
                xfer(1'b1, 1'b0, 1'b1);
                for (int k = 0; k < 3; k++)
                    xfer(1'b1, 1'b1, 1'b1);
                xfer(1'b0, 1'b1, 1'b1);
                xfer(1'b1, 1'b1, 1'b1);
                drain();
                // Overfill: the last two writes are dropped
                fillHold <= 1'b1;
                for (int k = 0; k < 18; k++)
                    xfer(1'b0, k[0], k < 16);
                fillHold <= 1'b0;
                drain();
                repeat (20) @(posedge clk);
            end else begin
                reqValid <= 1'b1;
                padHold <= 1'b1;
                @(posedge clk);
                for (int v = 0; v < 4; v++) begin
                    floatPad <= 8'(v);
                    repeat (5) @(posedge clk);
                    `CHK({serialData, serialClk, reqReady}, {2'(v), 1'b0})
                end
                `CHK(bus.cmdDataSelect, 1'b0)
                reqValid <= 1'b0;
                padHold <= 1'b0;
            end
        end
        `CHK(rdQ.size() == 0, 1'b1)
        endSim();
    end
endmodule : testbench
